// *** core/brt_rtc_sram.sv ***
// 8k x 8 static memory with calendar clock bytes at the top of the map
// and a power-fail alert and deselect; the supply comparator arrives as one input
// assumes all pins are synchronous to clk; no external buffer on the data bus
//
// Behaviour
// - clock bytes live at the eight highest addresses 1ff8..1fff
// - time bytes hold bcd year, month, date, day, hour, minute, second; 24 hour
// - date rolls for 28, 30, 31 day months and 29 for leap february
// - byte 1ff8 is the control register: access control and calibration
// - time bytes are separate cells, refreshed from the counters once per second
// - clock bytes use exactly the same bus cycles as ordinary memory
// - automatic deselect follows the alert by 10 to 40 us
// - alert released once supply is back, at most 120 us after upper trip
// - on a fast supply fall deselect may lag up to 200 us
// - alert asserts as soon as supply reaches the detect threshold
// - while deselected, the data outputs float and all bus inputs are ignored; the alert pin stays driven until supply returns
// - control bit 7 write, bit 6 read, bit 5 sign, low bits magnitude
`timescale 1ns/1ps
`default_nettype none
module brt_rtc_sram #(
    parameter int TICK_CYCLES = brt_pkg::SECOND_CYC,
    parameter int RECOVERY_CYCLES = brt_pkg::POWER_UP_RECOVERY_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // memory bus
    input wire logic [brt_pkg::ADDR_W-1:0] address,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic first_select_n,
    input wire logic second_select,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    // supply monitor
    input wire logic vcc_below_trip,
    // open-drain power-fail alert
    output logic int_n_out,
    output logic int_n_oe
);
    localparam int REC_W = $clog2(RECOVERY_CYCLES + 1);
    localparam int PRE_W = $clog2(TICK_CYCLES + 64);
    localparam int PF_W = $clog2(brt_pkg::ALERT_TO_DESELECT_CYC + 1);

    typedef struct packed {
        brt_pkg::brt_ctl_t ctl;
        logic [6:0][7:0] tbytes;
        logic [7:0] rdata;
        logic alert;
        logic desel;
        logic [PF_W-1:0] pf_cnt;
        logic [REC_W-1:0] rec_cnt;
        logic [PRE_W-1:0] pre;
        logic tick;
        logic copy;
        logic load;
    } brt_main_state_t;

    brt_main_state_t st_q, st_d;
    logic [7:0] mem [0:(1 << brt_pkg::ADDR_W) - 9];
    brt_pkg::brt_time_t now;
    logic active, wr, is_clock;
    logic [2:0] idx;
    logic [PRE_W-1:0] period_m1;

    // chip select decode; the deselect overrides both select pins
    assign active = !first_select_n && second_select && !st_q.desel;
    assign wr = active && !write_enable_n;
    assign is_clock = (address >= brt_pkg::CLOCK_CTL_ADDR);
    assign idx = address[2:0];

    // a set sign bit shortens the second, the clock runs faster
    always_comb begin
        if (st_q.ctl.cal_sign) begin
            period_m1 = PRE_W'(TICK_CYCLES - 1) - PRE_W'(st_q.ctl.cal_mag);
        end else begin
            period_m1 = PRE_W'(TICK_CYCLES - 1) + PRE_W'(st_q.ctl.cal_mag);
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        st_d.load = 1'b0;
        st_d.copy = st_q.tick;

        // oscillator halt stops the prescaler, the calendar then stands still
        if (st_q.tbytes[0][brt_pkg::HALT_BIT]) begin
            st_d.pre = '0;
        end else if (st_q.pre >= period_m1) begin
            st_d.pre = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.pre = st_q.pre + PRE_W'(1);
        end

        // refresh one cycle after the counters step, so the new value is taken
        // a pending load must not see its written time replaced by the old count
        if (st_q.copy && !st_q.load
                && !st_q.ctl.write_lock && !st_q.ctl.read_hold) begin
            st_d.tbytes = now;
            st_d.tbytes[0][brt_pkg::HALT_BIT] = st_q.tbytes[0][brt_pkg::HALT_BIT];
        end

        // host write wins over the refresh in the same cycle
        if (wr && is_clock) begin
            if (idx == brt_pkg::CTL_INDEX) begin
                st_d.ctl = dq_in;
                // releasing the write bit hands the written time to the counters
                st_d.load = st_q.ctl.write_lock && !dq_in[7];
            end else begin
                st_d.tbytes[idx - 3'd1] = dq_in;
            end
        end

        if (is_clock) begin
            st_d.rdata = (idx == brt_pkg::CTL_INDEX) ? st_q.ctl : st_q.tbytes[idx - 3'd1];
        end else begin
            st_d.rdata = mem[address];
        end

        // power-fail alert and timed deselect
        if (vcc_below_trip) begin
            st_d.alert = 1'b1;
            st_d.rec_cnt = '0;
            // the fixed 10 us delay also meets the slower limit on a fast fall
            if (!st_q.desel) begin
                if (st_q.pf_cnt == PF_W'(brt_pkg::ALERT_TO_DESELECT_CYC)) begin
                    st_d.desel = 1'b1;
                end else begin
                    st_d.pf_cnt = st_q.pf_cnt + PF_W'(1);
                end
            end
        end else begin
            st_d.alert = 1'b0;
            st_d.pf_cnt = '0;
            // write protection holds through the recovery time after power-up
            if (st_q.desel) begin
                if (st_q.rec_cnt == REC_W'(RECOVERY_CYCLES - 1)) begin
                    st_d.desel = 1'b0;
                    st_d.rec_cnt = '0;
                end else begin
                    st_d.rec_cnt = st_q.rec_cnt + REC_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= '{ctl: brt_pkg::CTL_RESET, tbytes: brt_pkg::TIME_RESET, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // array contents are not reset: they stand for battery-backed cells
    always_ff @(posedge clk) begin
        if (wr && !is_clock) begin
            mem[address] <= dq_in;
        end
    end

    brt_calendar u_calendar (
        .clk(clk),
        .reset_n(reset_n),
        .tick(st_q.tick),
        .halt(st_q.tbytes[0][brt_pkg::HALT_BIT]),
        .load(st_q.load),
        .load_time(brt_pkg::brt_time_t'(st_q.tbytes)),
        .now(now)
    );

    // read data lags the address by one clock
    assign dq_out = st_q.rdata;
    assign dq_oe = active && !output_enable_n && write_enable_n;
    assign int_n_out = 1'b0;
    assign int_n_oe = st_q.alert;

    default clocking cb_main @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_INT_ON: assert property (vcc_below_trip |=> int_n_oe)
        else $error("alert not asserted after supply trip");
    AST_DESEL_DELAY: assert property ($rose(st_q.desel) |->
        $past(int_n_oe, 250) && !$past(int_n_oe, 251))
        else $error("deselect not 10 us after alert");
    AST_INT_RELEASE: assert property ($fell(vcc_below_trip) |-> ##[1:2] !int_n_oe)
        else $error("alert not released after supply recovery");
    AST_FLOAT: assert property (st_q.desel |-> !dq_oe)
        else $error("data driven while deselected");
    AST_PROTECT: assert property (st_q.desel && $past(st_q.desel) |-> $stable(st_q.ctl))
        else $error("control byte changed while deselected");
    AST_LOCK_HOLD: assert property (st_q.copy && st_q.ctl.write_lock && !wr
        |=> $stable(st_q.tbytes))
        else $error("time bytes refreshed while write bit set");
    AST_COPY: assert property (st_q.copy && !st_q.ctl.write_lock && !st_q.ctl.read_hold
        && !wr && !st_q.load
        |=> st_q.tbytes[1] == $past(now.minute) && st_q.tbytes[6] == $past(now.year))
        else $error("time bytes not refreshed from counters");
    AST_CTL_READ: assert property (active && write_enable_n
        && address == brt_pkg::CLOCK_CTL_ADDR |=> dq_out == $past(st_q.ctl))
        else $error("control byte read back wrong");

    COV_ALERT: cover property ($rose(int_n_oe));
    COV_DESEL: cover property ($rose(st_q.desel));
    COV_COPY: cover property (st_q.copy && !st_q.ctl.write_lock);
    COV_LOAD: cover property (st_q.load);
endmodule
`default_nettype wire

// *** common/brt_pkg.sv ***
// shared constants and types of the battery-backed calendar clock
// assumes a single 25 MHz clock and synchronous inputs
package brt_pkg;
    // time base
    localparam int CLK_MHZ = 25;
    localparam int SECOND_CYC = CLK_MHZ * 1_000_000;
    // power-fail timing, alert to deselect must fall in 10..40 us
    localparam int ALERT_TO_DESELECT_US = 10;
    localparam int ALERT_TO_DESELECT_CYC = ALERT_TO_DESELECT_US * CLK_MHZ;
    // power-up recovery, value not given: plain 1 ms default
    localparam int POWER_UP_RECOVERY_US = 1000;
    localparam int POWER_UP_RECOVERY_CYC = POWER_UP_RECOVERY_US * CLK_MHZ;
    // memory map
    localparam int ADDR_W = 13;
    localparam logic [12:0] CLOCK_CTL_ADDR = 13'h1ff8;
    localparam logic [2:0] CTL_INDEX = 3'h0;
    localparam int HALT_BIT = 7;
    localparam int CAL_W = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;

    typedef struct packed {
        logic write_lock;
        logic read_hold;
        logic cal_sign;
        logic [CAL_W-1:0] cal_mag;
    } brt_ctl_t;

    // field order matches the byte order 1fff down to 1ff9
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } brt_time_t;

    localparam brt_time_t TIME_RESET = '{year: 8'h00, month: 8'h01, date: 8'h01,
        day: 8'h01, hour: 8'h00, minute: 8'h00, second: 8'h00};
endpackage

// *** core/brt_calendar.sv ***
// bcd running counters: seconds through year, with leap-year february
// assumes tick is a one-cycle pulse at most once per second
`timescale 1ns/1ps
`default_nettype none
module brt_calendar (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic tick,
    input wire logic halt,
    input wire logic load,
    input wire brt_pkg::brt_time_t load_time,
    // running time
    output brt_pkg::brt_time_t now
);
    typedef struct packed {
        brt_pkg::brt_time_t t;
    } brt_cal_state_t;

    brt_cal_state_t st_q, st_d;

    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction

    // 00 is taken as a leap year, the two-digit year has no century
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        case (m)
            8'h02: month_days = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
            default: month_days = 8'h31;
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        if (load) begin
            st_d.t = load_time;
            st_d.t.second[7] = 1'b0;
        end else if (tick && !halt) begin
            if (st_q.t.second == 8'h59) begin
                st_d.t.second = 8'h00;
                if (st_q.t.minute == 8'h59) begin
                    st_d.t.minute = 8'h00;
                    if (st_q.t.hour == 8'h23) begin
                        st_d.t.hour = 8'h00;
                        st_d.t.day = (st_q.t.day == 8'h07) ? 8'h01 : bcd_inc(st_q.t.day);
                        if (st_q.t.date == month_days(st_q.t.month, st_q.t.year)) begin
                            st_d.t.date = 8'h01;
                            if (st_q.t.month == 8'h12) begin
                                st_d.t.month = 8'h01;
                                st_d.t.year = (st_q.t.year == 8'h99) ? 8'h00 : bcd_inc(st_q.t.year);
                            end else begin
                                st_d.t.month = bcd_inc(st_q.t.month);
                            end
                        end else begin
                            st_d.t.date = bcd_inc(st_q.t.date);
                        end
                    end else begin
                        st_d.t.hour = bcd_inc(st_q.t.hour);
                    end
                end else begin
                    st_d.t.minute = bcd_inc(st_q.t.minute);
                end
            end else begin
                st_d.t.second = bcd_inc(st_q.t.second);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= '{t: brt_pkg::TIME_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign now = st_q.t;

    default clocking cb_cal @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_HOUR_24: assert property (now.hour <= 8'h23)
        else $error("hour left the 24 hour range");
    AST_SEC_BCD: assert property (now.second[3:0] <= 4'h9 && now.second[7:4] <= 4'h5)
        else $error("seconds not valid bcd");
    AST_DATE_MAX: assert property (now.date <= 8'h31 && now.date != 8'h00)
        else $error("date out of range");
    AST_FEB_ROLL: assert property (tick && !halt && !load && now.month == 8'h02
        && now.date == 8'h29 && now.hour == 8'h23 && now.minute == 8'h59
        && now.second == 8'h59 |=> now.date == 8'h01 && now.month == 8'h03)
        else $error("february 29 did not roll to march 1");
    COV_YEAR_ROLL: cover property (tick && now.month == 8'h12 && now.date == 8'h31
        && now.hour == 8'h23 && now.minute == 8'h59 && now.second == 8'h59);
endmodule
`default_nettype wire

// *** verif/brt_host_model.sv ***
// host processor on the static memory bus: byte writes, byte reads, idle
// assumes the device samples its pins on the rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module brt_host_model (
    // clock
    input wire logic clk,
    // bus towards the device
    output logic [12:0] address,
    output logic [7:0] dq_in,
    output logic first_select_n,
    output logic second_select,
    output logic output_enable_n,
    output logic write_enable_n,
    // bus from the device
    input wire logic [7:0] dq_out,
    input wire logic dq_oe
);
    logic [7:0] last_q;

    initial begin
        address = 13'h0000;
        dq_in = 8'h00;
        first_select_n = 1'b1;
        second_select = 1'b0;
        output_enable_n = 1'b1;
        write_enable_n = 1'b1;
        last_q = 8'h00;
    end

    // one plain memory cycle, clock bytes included
    task automatic bus_write(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        dq_in <= d;
        first_select_n <= 1'b0;
        second_select <= 1'b1;
        output_enable_n <= 1'b1;
        write_enable_n <= 1'b0;
        @(posedge clk);
        write_enable_n <= 1'b1;
        // released data lines must not keep the old value
        dq_in <= ~d;
    endtask

    // read data is registered, so it is taken one edge after the address
    task automatic bus_read(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk);
        address <= a;
        first_select_n <= 1'b0;
        second_select <= 1'b1;
        output_enable_n <= 1'b0;
        write_enable_n <= 1'b1;
        @(posedge clk);
        #1;
        // an undriven bus shows the inverse of the last value, never a lucky match
        d = dq_oe ? dq_out : ~last_q;
        last_q = d;
    endtask

    // first select held high while supply returns, so no stray write lands
    task automatic bus_idle(input int n);
        @(posedge clk);
        first_select_n <= 1'b1;
        output_enable_n <= 1'b1;
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** verif/test_brt_rtc_sram.sv ***
// self-checking bench of the clock memory: bus reads and writes with expected values
// assumes the host model drives the bus and the bench drives the supply monitor
`timescale 1ns/1ps
`default_nettype none
module test_brt_rtc_sram;
    localparam int TICK = 50;
    localparam int RECOV = 20;
    localparam logic [12:0] CTL = brt_pkg::CLOCK_CTL_ADDR;
    // before and after one second: year month date day hour minute second
    localparam logic [55:0] CAL_IN [5] = '{56'h24_02_28_07_23_59_59,
        56'h23_02_28_03_23_59_59, 56'h24_04_30_01_23_59_59,
        56'h99_12_31_05_23_59_59, 56'h24_02_29_02_23_59_59};
    localparam logic [55:0] CAL_EXP [5] = '{56'h24_02_29_01_00_00_00,
        56'h23_03_01_04_00_00_00, 56'h24_05_01_02_00_00_00,
        56'h00_01_01_06_00_00_00, 56'h24_03_01_03_00_00_00};
    logic clk, reset_n, vcc_below_trip, first_select_n, second_select;
    logic output_enable_n, write_enable_n, dq_oe, int_n_out, int_n_oe;
    logic [12:0] address;
    logic [7:0] dq_in, dq_out;
    logic [55:0] time_rst;
    int err_total, checks_done;
    // the alert pin has a pull-up, so a released pin reads high
    wire logic int_n_level = int_n_oe ? int_n_out : 1'b1;

    brt_rtc_sram #(.TICK_CYCLES(TICK), .RECOVERY_CYCLES(RECOV)) brt_rtc_sram_i (
        .clk(clk), .reset_n(reset_n), .address(address), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .first_select_n(first_select_n),
        .second_select(second_select), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .vcc_below_trip(vcc_below_trip),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe));
    brt_host_model brt_host_model_i (
        .clk(clk), .address(address), .dq_in(dq_in), .first_select_n(first_select_n),
        .second_select(second_select), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .dq_out(dq_out), .dq_oe(dq_oe));

    always #20 clk = ~clk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] exp, input string what);
        logic [7:0] got;
        brt_host_model_i.bus_read(a, got);
        check(what, exp, got);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        int i, k;
        logic [7:0] v0;
        clk = 1'b0;
        reset_n = 1'b0;
        vcc_below_trip = 1'b0;
        err_total = 0;
        checks_done = 0;
        time_rst = brt_pkg::TIME_RESET;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // reads finish well inside the first second
        rd_chk(CTL, brt_pkg::CTL_RESET, "control reset");
        for (i = 0; i < 7; i++) begin
            rd_chk(13'(13'h1ff9 + i), time_rst[8*i +: 8], "time reset");
        end
        $display("test reset values done");
        brt_host_model_i.bus_write(13'h0000, 8'ha5);
        brt_host_model_i.bus_write(13'h1ff7, 8'h5a);
        rd_chk(13'h0000, 8'ha5, "memory 0000");
        rd_chk(13'h1ff7, 8'h5a, "memory 1ff7");
        $display("test plain memory done");
        brt_host_model_i.bus_write(CTL, 8'h5f);
        rd_chk(CTL, 8'h5f, "control fields");
        brt_host_model_i.bus_read(13'h1ff9, v0);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(13'h1ff9, v0, "seconds frozen by read bit");
        brt_host_model_i.bus_write(CTL, 8'h00);
        $display("test read bit done");
        for (k = 0; k < 5; k++) begin
            brt_host_model_i.bus_write(CTL, 8'h80);
            for (i = 0; i < 7; i++) begin
                brt_host_model_i.bus_write(13'(13'h1ff9 + i), CAL_IN[k][8*i +: 8]);
            end
            if (k == 0) begin
                repeat (3 * TICK) @(posedge clk);
                rd_chk(13'h1ff9, 8'h59, "seconds kept under write bit");
            end
            brt_host_model_i.bus_write(CTL, 8'h00);
            v0 = 8'hff;
            for (i = 0; i < 100 && v0 !== 8'h00; i++) begin
                brt_host_model_i.bus_read(13'h1ff9, v0);
            end
            check("seconds rollover", 8'h00, v0);
            if (v0 !== 8'h00) begin
                give_verdict();
            end
            for (i = 1; i < 7; i++) begin
                rd_chk(13'(13'h1ff9 + i), CAL_EXP[k][8*i +: 8], "calendar byte");
            end
        end
        $display("test calendar rollover done");
        brt_host_model_i.bus_write(13'h1ff9, 8'h80);
        repeat (3 * TICK) @(posedge clk);
        rd_chk(13'h1ff9, 8'h80, "seconds stopped by halt bit");
        brt_host_model_i.bus_write(13'h1ff9, 8'h00);
        $display("test halt bit done");
        brt_host_model_i.bus_read(13'h0000, v0);
        @(posedge clk);
        vcc_below_trip <= 1'b1;
        @(posedge clk);
        #1;
        check("alert pin on trip", 8'h00, {7'h00, int_n_level});
        repeat (249) @(posedge clk);
        #1;
        check("drive before 10 us", 8'h01, {7'h00, dq_oe});
        repeat (6) @(posedge clk);
        #1;
        check("drive after deselect", 8'h00, {7'h00, dq_oe});
        brt_host_model_i.bus_write(13'h0000, 8'h3c);
        @(posedge clk);
        vcc_below_trip <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("alert released", 8'h01, {7'h00, int_n_level});
        brt_host_model_i.bus_idle(RECOV + 10);
        rd_chk(13'h0000, 8'ha5, "memory protected");
        $display("test power fail done");
        give_verdict();
    end
endmodule
`default_nettype wire
